// file: hdl/pump_seq_consts.vh
// register map, field positions, reset values and timing figures for pump sequencing
`ifndef PUMP_SEQ_CONSTS_VH
`define PUMP_SEQ_CONSTS_VH

`define CLOCK_HZ            125000000
`define TENTHS_PER_SECOND   10
`define SECONDS_PER_HOUR    3600

`define OFS_CTRL            8'h00
`define OFS_STATUS          8'h04
`define OFS_RUN_ON_INTERVAL 8'h08
`define OFS_RUN_ON_DURATION 8'h0C
`define OFS_START_SPACING   8'h10
`define OFS_RESUME_DELAY    8'h14
`define OFS_JITTER_RANGE0   8'h18
`define OFS_JITTER_RANGE1   8'h1C
`define OFS_JITTER_RANGE2   8'h20
`define OFS_FLUSH_WATCHED   8'h24
`define OFS_FLUSH_CYCLES    8'h28
`define OFS_FLUSH_INTERVAL  8'h2C
`define OFS_FLUSH_ON_TIME   8'h30
`define OFS_RELAY_CFG0      8'h40

`define CTRL_SIM_BIT        0
`define CTRL_RATE_BIT       1
`define CTRL_OP_LSB         4
`define OP_DUAL_A           3'h4
`define OP_DUAL_B           3'h5

`define CFG_GROUP_BIT       8
`define CFG_WATCH_LSB       12

`define FUNC_PUMP_FIRST     7'h32
`define FUNC_PUMP_LAST      7'h38
`define FUNC_ALT_ASSIST     7'h34
`define FUNC_ALT_BACKUP     7'h35
`define FUNC_FLUSH_VALVE    7'h40

`define RST_SPACING         14'h000A
`define RST_RESUME_DELAY    14'h000A
`define MAX_INTERVAL_HOURS  10'h3E8
`define MAX_SETTING         14'h270F
`define MAX_WATCHED         3'h5

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: hdl/pump_seq.v
// pump start spacing, run-on, power resume hold, setpoint jitter and flush valve control
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "pump_seq_consts.vh"

// What this block does
// - modifiers touch only pump-function relays
// - run-on interval in hours, 0..1000, default 0
// - run-on extends only the last running pump
// - run-on duration in seconds, 0..9999
// - minimum spacing between pump starts, default 10 s
// - simulation mode uses one tenth spacing
// - power resume holds first start, default 10 s
// - after resume hold, normal start spacing applies
// - setpoints jittered randomly within range, per transducer
// - pumps in group 1 or 2, group flagged per relay on pump_group
// - grouping only for alternate duty functions
// - flush inactive when any flush setting zero
// - single point: one watched relay drives flush
// - dual point: per-relay setting names watched pump
// - dual point: separate flush valve per input
// - watched pump number 0..5, default 0
// - count cycles, new flush period per interval
// - flush the configured number of cycles per period
// - flush valve held for configured duration
// - pump-by-rate starts spaced by start spacing
module pump_seq #(
  parameter RELAYS   = 6,
  parameter INPUTS   = 3,
  parameter CLOCK_HZ = `CLOCK_HZ
) (
  input  wire                 clock,
  input  wire                 rst_n,
  input  wire [RELAYS-1:0]    relay_demand,
  input  wire                 power_restored,
  output reg  [RELAYS-1:0]    relay_out,
  output reg  [RELAYS-1:0]    pump_group,
  output reg  [14*INPUTS-1:0] jitter_on_offset,
  output reg  [14*INPUTS-1:0] jitter_off_offset,
  input  wire [7:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [7:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready
);

  localparam TENTH_CYCLES = CLOCK_HZ / `TENTHS_PER_SECOND;

  // settings
  reg        sim_mode_r;
  reg        pump_by_rate_enable_r;
  reg [2:0]  operation_select_r;
  reg [9:0]  run_on_interval_r;
  reg [13:0] run_on_duration_r;
  reg [13:0] pump_start_spacing_r;
  reg [13:0] power_resume_delay_r;
  reg [14*INPUTS-1:0] setpoint_jitter_range_r;
  reg [2:0]  flush_watched_pump_r;
  reg [13:0] flush_cycle_count_r;
  reg [13:0] flush_interval_count_r;
  reg [13:0] flush_on_time_r;
  reg [6:0]  relay_function_select_r [0:RELAYS-1];
  reg        pump_group_select_r [0:RELAYS-1];
  reg [2:0]  relay_watch_r [0:RELAYS-1];

  function is_pump;
    input [6:0] f;
    begin
      is_pump = (f >= `FUNC_PUMP_FIRST) && (f <= `FUNC_PUMP_LAST);
    end
  endfunction

  function [13:0] clamp14;
    input [31:0] v;
    begin
      clamp14 = (v[31:14] != 18'h0 || v[13:0] > `MAX_SETTING) ? `MAX_SETTING : v[13:0];
    end
  endfunction

  wire dual_point = (operation_select_r == `OP_DUAL_A) || (operation_select_r == `OP_DUAL_B);

  // time base: tenth-second divider, then seconds and hours
  reg [26:0] div_r;
  reg [3:0]  tenth_cnt_r;
  reg [11:0] sec_cnt_r;
  reg        tenth_tick;
  reg        sec_tick;
  reg        hour_tick;
  always @(posedge clock) begin
    tenth_tick <= 1'b0;
    sec_tick   <= 1'b0;
    hour_tick  <= 1'b0;
    if (!rst_n) begin
      div_r       <= 27'h0;
      tenth_cnt_r <= 4'h0;
      sec_cnt_r   <= 12'h0;
    end else if (div_r == TENTH_CYCLES[26:0] - 27'h1) begin
      div_r      <= 27'h0;
      tenth_tick <= 1'b1;
      if (tenth_cnt_r == 4'h9) begin
        tenth_cnt_r <= 4'h0;
        sec_tick    <= 1'b1;
        if (sec_cnt_r == `SECONDS_PER_HOUR - 1) begin
          sec_cnt_r <= 12'h0;
          hour_tick <= 1'b1;
        end else begin
          sec_cnt_r <= sec_cnt_r + 12'h1;
        end
      end else begin
        tenth_cnt_r <= tenth_cnt_r + 4'h1;
      end
    end else begin
      div_r <= div_r + 27'h1;
    end
  end

  // power restore pin synchroniser and edge
  reg pwr_meta_r;
  reg pwr_sync_r;
  reg pwr_prev_r;
  always @(posedge clock) begin
    if (!rst_n) begin
      pwr_meta_r <= 1'b0;
      pwr_sync_r <= 1'b0;
      pwr_prev_r <= 1'b0;
    end else begin
      pwr_meta_r <= power_restored;
      pwr_sync_r <= pwr_meta_r;
      pwr_prev_r <= pwr_sync_r;
    end
  end
  wire pwr_edge = pwr_sync_r & ~pwr_prev_r;

  // pump sequencing
  reg [RELAYS-1:0] pump_on_r;
  reg [RELAYS-1:0] run_on_sel_r;
  reg [13:0]       run_on_cnt_r;
  reg [9:0]        hours_r;
  reg              run_on_due_r;
  reg [13:0]       spacing_cnt_r;
  reg [13:0]       resume_cnt_r;
  reg              resume_load_r;

  wire [RELAYS-1:0] pump_mask;
  wire [RELAYS-1:0] flush_mask;
  wire [RELAYS-1:0] flush_valve;
  genvar g;
  generate
    for (g = 0; g < RELAYS; g = g + 1) begin : fmask
      assign pump_mask[g]  = is_pump(relay_function_select_r[g]);
      assign flush_mask[g] = (relay_function_select_r[g] == `FUNC_FLUSH_VALVE);
    end
  endgenerate

  wire              resume_hold = (resume_cnt_r != 14'h0) | resume_load_r;
  wire              start_ok    = ~resume_hold & (spacing_cnt_r == 14'h0);
  wire [RELAYS-1:0] start_cand  = pump_mask & relay_demand & ~pump_on_r;
  wire [RELAYS-1:0] start_sel   = start_ok ? (start_cand & ~(start_cand - 1'b1)) : {RELAYS{1'b0}};
  wire [RELAYS-1:0] stop_cand   = pump_mask & pump_on_r & ~relay_demand & ~run_on_sel_r;
  wire              last_pump   = (stop_cand == pump_on_r) && ((stop_cand & (stop_cand - 1'b1)) == 0);
  wire              begin_runon = run_on_due_r && (run_on_sel_r == 0) && last_pump
                                  && (stop_cand != 0) && (run_on_duration_r != 14'h0);
  wire              spacing_tick = sim_mode_r ? tenth_tick : sec_tick;

  always @(posedge clock) begin
    if (!rst_n) begin
      pump_on_r     <= {RELAYS{1'b0}};
      run_on_sel_r  <= {RELAYS{1'b0}};
      run_on_cnt_r  <= 14'h0;
      hours_r       <= 10'h0;
      run_on_due_r  <= 1'b0;
      spacing_cnt_r <= 14'h0;
      resume_cnt_r  <= 14'h0;
      resume_load_r <= 1'b1;
    end else begin
      // delay reloads at reset release and on each power return
      if (resume_load_r || pwr_edge) begin
        resume_cnt_r  <= power_resume_delay_r;
        resume_load_r <= 1'b0;
      end else if (sec_tick && resume_cnt_r != 14'h0) begin
        resume_cnt_r <= resume_cnt_r - 14'h1;
      end
      // spacing also covers rate mode; the rate logic only raises demand
      if (start_sel != 0) begin
        spacing_cnt_r <= pump_start_spacing_r;
      end else if (spacing_tick && spacing_cnt_r != 14'h0) begin
        spacing_cnt_r <= spacing_cnt_r - 14'h1;
      end
      if (run_on_interval_r == 10'h0) begin
        hours_r <= 10'h0;
      end else if (hour_tick) begin
        if (hours_r + 10'h1 >= run_on_interval_r) begin
          hours_r <= 10'h0;
        end else begin
          hours_r <= hours_r + 10'h1;
        end
      end
      // a new due event wins over the clear by a starting run-on
      if (hour_tick && run_on_interval_r != 10'h0 && hours_r + 10'h1 >= run_on_interval_r) begin
        run_on_due_r <= 1'b1;
      end else if (begin_runon || run_on_interval_r == 10'h0) begin
        run_on_due_r <= 1'b0;
      end
      if (begin_runon) begin
        run_on_sel_r <= stop_cand;
        run_on_cnt_r <= run_on_duration_r;
      end else if (run_on_sel_r != 0) begin
        if ((run_on_sel_r & relay_demand) != 0 || run_on_cnt_r == 14'h0) begin
          run_on_sel_r <= {RELAYS{1'b0}};
        end else if (sec_tick) begin
          run_on_cnt_r <= run_on_cnt_r - 14'h1;
        end
      end
      pump_on_r <= ((pump_on_r & ~stop_cand) | start_sel | (stop_cand & {RELAYS{begin_runon}}))
                   & pump_mask & (relay_demand | run_on_sel_r | start_sel
                   | (stop_cand & {RELAYS{begin_runon}}))
                   & ~(run_on_sel_r & ~relay_demand & {RELAYS{run_on_sel_r != 0
                   && run_on_cnt_r == 14'h0 && !begin_runon}});
    end
  end

  // flush engines, one per relay index
  wire flush_cfg_ok = (flush_cycle_count_r != 14'h0) && (flush_interval_count_r != 14'h0)
                      && (flush_on_time_r != 14'h0);
  generate
    for (g = 0; g < RELAYS; g = g + 1) begin : flush
      reg [13:0] cycles_r;
      reg [13:0] left_r;
      reg [13:0] timer_r;
      reg        watched_prev_r;
      // relay numbers count from 1; zero means no watched pump
      wire [2:0] watch_num = dual_point ? relay_watch_r[g] : flush_watched_pump_r;
      wire       watch_ok  = (watch_num != 3'h0) && (watch_num <= `MAX_WATCHED);
      wire       watched   = watch_ok ? pump_on_r[watch_num - 3'h1] : 1'b0;
      wire       cycle_evt = watched & ~watched_prev_r;
      wire       enabled   = flush_cfg_ok & watch_ok & flush_mask[g];
      assign flush_valve[g] = enabled & (timer_r != 14'h0);
      always @(posedge clock) begin
        if (!rst_n || !enabled) begin
          cycles_r       <= 14'h0;
          left_r         <= 14'h0;
          timer_r        <= 14'h0;
          watched_prev_r <= watched;
        end else begin
          watched_prev_r <= watched;
          if (cycle_evt && left_r != 14'h0) begin
            timer_r <= flush_on_time_r + 14'h1;
          end else if (sec_tick && timer_r != 14'h0) begin
            timer_r <= timer_r - 14'h1;
          end
          if (cycle_evt) begin
            if (cycles_r + 14'h1 >= flush_interval_count_r) begin
              cycles_r <= 14'h0;
              left_r   <= flush_cycle_count_r;
            end else begin
              cycles_r <= cycles_r + 14'h1;
              if (left_r != 14'h0) begin
                left_r <= left_r - 14'h1;
              end
            end
          end
        end
      end
    end
  endgenerate

  // relay drive and grouping
  integer k;
  integer n;
  always @(posedge clock) begin
    if (!rst_n) begin
      relay_out  <= {RELAYS{1'b0}};
      pump_group <= {RELAYS{1'b0}};
    end else begin
      relay_out <= (pump_on_r & pump_mask) | (flush_valve & flush_mask)
                   | (relay_demand & ~pump_mask & ~flush_mask);
      for (k = 0; k < RELAYS; k = k + 1) begin
        pump_group[k] <= pump_group_select_r[k]
                         && (relay_function_select_r[k] == `FUNC_ALT_ASSIST
                         || relay_function_select_r[k] == `FUNC_ALT_BACKUP);
      end
    end
  end

  // setpoint jitter: new offsets drawn at each pump start
  reg [15:0] lfsr_r;
  always @(posedge clock) begin
    if (!rst_n) begin
      lfsr_r <= 16'hACE1;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end
  generate
    for (g = 0; g < INPUTS; g = g + 1) begin : jit
      wire [13:0] range  = dual_point ? setpoint_jitter_range_r[14*g +: 14]
                                      : setpoint_jitter_range_r[13:0];
      wire [15:0] rnd_a  = lfsr_r ^ (16'h3C5A << g);
      wire [15:0] rnd_b  = {lfsr_r[7:0], lfsr_r[15:8]} ^ (16'h5A3C << g);
      wire [29:0] prod_a = rnd_a * range;
      wire [29:0] prod_b = rnd_b * range;
      always @(posedge clock) begin
        if (!rst_n) begin
          jitter_on_offset[14*g +: 14]  <= 14'h0;
          jitter_off_offset[14*g +: 14] <= 14'h0;
        end else if (start_sel != 0 || range == 14'h0) begin
          jitter_on_offset[14*g +: 14]  <= prod_a[29:16];
          jitter_off_offset[14*g +: 14] <= prod_b[29:16];
        end
      end
    end
  endgenerate

  // AXI4-Lite slave
  reg        aw_full_r;
  reg        w_full_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire [31:0] wmerged = w_data_r;
  wire        do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire        wr_cfg   = (aw_addr_r >= `OFS_RELAY_CFG0)
                         && (aw_addr_r < `OFS_RELAY_CFG0 + 4 * RELAYS) && (aw_addr_r[1:0] == 2'h0);
  wire [2:0]  wr_idx   = aw_addr_r[4:2];

  function wr_ok;
    input [7:0] a;
    begin
      wr_ok = (a[1:0] == 2'h0) && ((a <= `OFS_FLUSH_ON_TIME && a != `OFS_STATUS)
              || (a >= `OFS_RELAY_CFG0 && a < `OFS_RELAY_CFG0 + 4 * RELAYS));
    end
  endfunction

  always @(posedge clock) begin
    if (!rst_n) begin
      aw_full_r    <= 1'b0;
      w_full_r     <= 1'b0;
      aw_addr_r    <= 8'h0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      sim_mode_r             <= 1'b0;
      pump_by_rate_enable_r  <= 1'b0;
      operation_select_r     <= 3'h0;
      run_on_interval_r      <= 10'h0;
      run_on_duration_r      <= 14'h0;
      pump_start_spacing_r   <= `RST_SPACING;
      power_resume_delay_r   <= `RST_RESUME_DELAY;
      setpoint_jitter_range_r <= {14*INPUTS{1'b0}};
      flush_watched_pump_r   <= 3'h0;
      flush_cycle_count_r    <= 14'h0;
      flush_interval_count_r <= 14'h0;
      flush_on_time_r        <= 14'h0;
      for (n = 0; n < RELAYS; n = n + 1) begin
        relay_function_select_r[n] <= 7'h0;
        pump_group_select_r[n]     <= 1'b0;
        relay_watch_r[n]           <= 3'h0;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
        // settings are narrow; full-word writes expected, partial strobes ignored
        if (w_strb_r == 4'hF) begin
          case (aw_addr_r)
            `OFS_CTRL: begin
              sim_mode_r            <= wmerged[`CTRL_SIM_BIT];
              pump_by_rate_enable_r <= wmerged[`CTRL_RATE_BIT];
              operation_select_r    <= wmerged[`CTRL_OP_LSB +: 3];
            end
            `OFS_RUN_ON_INTERVAL: run_on_interval_r <= (wmerged > {22'h0, `MAX_INTERVAL_HOURS})
                                  ? `MAX_INTERVAL_HOURS : wmerged[9:0];
            `OFS_RUN_ON_DURATION: run_on_duration_r      <= clamp14(wmerged);
            `OFS_START_SPACING:   pump_start_spacing_r   <= clamp14(wmerged);
            `OFS_RESUME_DELAY:    power_resume_delay_r   <= clamp14(wmerged);
            `OFS_JITTER_RANGE0:   setpoint_jitter_range_r[13:0] <= clamp14(wmerged);
            `OFS_JITTER_RANGE1:   setpoint_jitter_range_r[27:14] <= clamp14(wmerged);
            `OFS_JITTER_RANGE2:   setpoint_jitter_range_r[41:28] <= clamp14(wmerged);
            `OFS_FLUSH_WATCHED:   flush_watched_pump_r   <= (wmerged > {29'h0, `MAX_WATCHED})
                                  ? `MAX_WATCHED : wmerged[2:0];
            `OFS_FLUSH_CYCLES:    flush_cycle_count_r    <= clamp14(wmerged);
            `OFS_FLUSH_INTERVAL:  flush_interval_count_r <= clamp14(wmerged);
            `OFS_FLUSH_ON_TIME:   flush_on_time_r        <= clamp14(wmerged);
            default: begin
              if (wr_cfg) begin
                relay_function_select_r[wr_idx] <= wmerged[6:0];
                pump_group_select_r[wr_idx]     <= wmerged[`CFG_GROUP_BIT];
                relay_watch_r[wr_idx]           <= wmerged[`CFG_WATCH_LSB +: 3];
              end
            end
          endcase
        end
      end
    end
  end

  reg [31:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `OFS_CTRL:            rd_val = {25'h0, operation_select_r, 2'h0,
                                      pump_by_rate_enable_r, sim_mode_r};
      `OFS_STATUS:          rd_val = {16'h0, flush_valve[5:0], resume_hold,
                                      spacing_cnt_r != 14'h0, run_on_sel_r != 0,
                                      run_on_due_r, relay_out[5:0]};
      `OFS_RUN_ON_INTERVAL: rd_val = {22'h0, run_on_interval_r};
      `OFS_RUN_ON_DURATION: rd_val = {18'h0, run_on_duration_r};
      `OFS_START_SPACING:   rd_val = {18'h0, pump_start_spacing_r};
      `OFS_RESUME_DELAY:    rd_val = {18'h0, power_resume_delay_r};
      `OFS_JITTER_RANGE0:   rd_val = {18'h0, setpoint_jitter_range_r[13:0]};
      `OFS_JITTER_RANGE1:   rd_val = {18'h0, setpoint_jitter_range_r[27:14]};
      `OFS_JITTER_RANGE2:   rd_val = {18'h0, setpoint_jitter_range_r[41:28]};
      `OFS_FLUSH_WATCHED:   rd_val = {29'h0, flush_watched_pump_r};
      `OFS_FLUSH_CYCLES:    rd_val = {18'h0, flush_cycle_count_r};
      `OFS_FLUSH_INTERVAL:  rd_val = {18'h0, flush_interval_count_r};
      `OFS_FLUSH_ON_TIME:   rd_val = {18'h0, flush_on_time_r};
      default: begin
        if (s_axi_araddr >= `OFS_RELAY_CFG0 && s_axi_araddr < `OFS_RELAY_CFG0 + 4 * RELAYS
            && s_axi_araddr[1:0] == 2'h0) begin
          rd_val = {17'h0, relay_watch_r[s_axi_araddr[4:2]], 3'h0,
                    pump_group_select_r[s_axi_araddr[4:2]], 1'b0,
                    relay_function_select_r[s_axi_araddr[4:2]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: testbench/pump_seq_asserts.sv
// port assertions for the pump sequencing block
`timescale 1ns/10ps
`default_nettype none
module pump_seq_asserts #(
  parameter CLOCK_HZ = 100
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [5:0]  relay_out,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] up_r;
  logic [5:0]  prev_r;
  // bench wires pumps on relays 0,1,2,4 only
  wire  [5:0]  ups = relay_out & ~prev_r & 6'h17;
  always @(posedge clock) begin
    prev_r <= rst_n ? relay_out : 6'h00;
    if (!rst_n) up_r <= 16'h0000;
    else if (up_r != 16'hFFFF) up_r <= up_r + 16'h0001;
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_HOLD_OFF: assert property (up_r < 9 * CLOCK_HZ |-> ups == 6'h00)
    else $error("start in hold");
  AST_START_GAP: assert property (ups != 6'h00 |=> (ups == 6'h00) [*8])
    else $error("starts too close");
  AST_B_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  AST_R_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("no read answer");
  AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp moved");
  AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata moved");
  AST_AR_SHUT: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready early");
  AST_W_SHUT: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready early");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
endmodule
bind pump_seq pump_seq_asserts #(.CLOCK_HZ(CLOCK_HZ)) u_chk (.clock, .rst_n, .relay_out,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: testbench/relay_load.sv
// load model: flush valve contactor on relay 5
`timescale 1ns/10ps
`default_nettype none
module relay_load (
  input wire logic       clock,
  input wire logic [5:0] relay_out,
  output var int         valve_cnt,
  output var int         valve_len
);
  int run;
  initial begin
    valve_cnt = 0;
    valve_len = 0;
    run = 0;
  end
  // valve contactor sits on relay 5
  always @(posedge clock) begin
    run <= relay_out[5] ? run + 1 : 0;
    if (relay_out[5] && run == 0) valve_cnt <= valve_cnt + 1;
    if (!relay_out[5] && run != 0) valve_len <= run;
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the pump sequencing block
`timescale 1ns/10ps
`default_nettype none
`include "pump_seq_consts.vh"
module testbench;
  logic        clock, rst_n, power_restored, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [5:0]  relay_demand, relay_out, pump_group;
  logic [41:0] jitter_on_offset, jitter_off_offset;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          error_cnt, tests_run, cyc, t0, valve_cnt, valve_len, i;
  logic [31:0] rq[$];
  logic [7:0]  ta[4] = '{8'h08, 8'h0C, 8'h10, 8'h24};
  logic [31:0] tw[4] = '{32'h7D0, 32'h4E20, 32'h3, 32'h7};
  logic [31:0] te[4] = '{32'h3E8, 32'h270F, 32'h3, 32'h5};
  logic [31:0] cf[6] = '{32'h134, 32'h35, 32'h132, 32'h101, 32'h32, 32'h40};
  // CLOCK_HZ of 100 makes one second 100 cycles
  pump_seq #(.CLOCK_HZ(100)) u_dut (.clock, .rst_n, .relay_demand, .power_restored, .relay_out,
    .pump_group, .jitter_on_offset, .jitter_off_offset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  relay_load u_load (.clock, .relay_out, .valve_cnt, .valve_len);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic chk_t(input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_v(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk_v(s_axi_rdata, e);
    chk_v(32'(s_axi_rresp), 32'(er));
  endtask
  // one watched pump cycle, long enough for a one second flush
  task automatic pcyc();
    relay_demand[0] <= 1'b0;
    go(40);
    relay_demand[0] <= 1'b1;
    go(260);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    {rst_n, power_restored, relay_demand, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, error_cnt, tests_run, cyc} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'hC9C4EADA;
    go(12);
    rst_n <= 1'b1;
    rc(`OFS_START_SPACING, 32'hA, `RESP_OKAY);
    rc(`OFS_RESUME_DELAY, 32'hA, `RESP_OKAY);
    rc(`OFS_FLUSH_WATCHED, 32'h0, `RESP_OKAY);
    rc(8'hFC, 32'h0, `RESP_SLVERR);
    wr(`OFS_STATUS, 32'h1, `RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      wr(ta[i], tw[i], `RESP_OKAY);
      rc(ta[i], te[i], `RESP_OKAY);
    end
    for (i = 0; i < 6; i++) wr(8'h40 + 8'(i * 4), cf[i], `RESP_OKAY);
    go(3);
    chk_v(32'(pump_group), 32'h1);
    for (i = 0; i < 24; i++) begin
      @(posedge clock);
      if (rq.size() == 2) chk_v(32'(relay_out[3]), rq.pop_front());
      q = rnd();
      relay_demand[3] <= q[0];
      rq.push_back(32'(q[0]));
    end
    go(1);
    relay_demand[3:0] <= 4'h3;
    while (cyc < 800) @(posedge clock);
    chk_v(32'(relay_out), 32'h0);
    while (!relay_out[0]) @(posedge clock);
    t0 = cyc;
    chk_t(t0, 905, 1130);
    while (!relay_out[1]) @(posedge clock);
    chk_t(cyc - t0, 200, 310);
    wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
    go(400);
    relay_demand[4:2] <= 3'h5;
    while (!relay_out[2]) @(posedge clock);
    t0 = cyc;
    while (!relay_out[4]) @(posedge clock);
    chk_t(cyc - t0, 20, 40);
    wr(`OFS_FLUSH_WATCHED, 32'h1, `RESP_OKAY);
    wr(`OFS_FLUSH_CYCLES, 32'h1, `RESP_OKAY);
    wr(`OFS_FLUSH_INTERVAL, 32'h2, `RESP_OKAY);
    repeat (3) pcyc();
    chk_v(32'(valve_cnt), 32'h0);
    wr(`OFS_FLUSH_ON_TIME, 32'h1, `RESP_OKAY);
    repeat (4) pcyc();
    chk_t(valve_cnt, 1, 1);
    chk_t(valve_len, 100, 205);
    chk_v(32'(|{jitter_on_offset, jitter_off_offset}), 32'h0);
    power_restored <= 1'b1;
    relay_demand[0] <= 1'b0;
    go(300);
    relay_demand[0] <= 1'b1;
    go(300);
    chk_v(32'(relay_out[0]), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
